/* core/wdrc_regs.svh */
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: apb with 32-bit data, one aligned word per register
// Notes:   printed offsets 0x13 is not a multiple of four, so indices are used
// How it works
// (RULE_01) unserviced counter reaching selected timeout raises a system reset
// (RULE_02) counter clocked by periodic tick, further divided by selected rate
// (RULE_03) writing zero to bit 0 of service location clears the counter
// (RULE_04) counter held cleared during reset or stop mode
// (RULE_05) rate bits accept only the first control write after reset
// (RULE_06) unwritten rate bits default to the one second setting
// (RULE_07) writing the rate bits clears the counter chain
// (RULE_08) bit set or clear is read-modify-write, locks rate if first write
// (RULE_09) rate 00,01,10,11 give 1,2,4,8 seconds at 32.768 kHz
// (RULE_10) illegal-stop flag set by disabled stop, cleared by por/ext/wdog
// (RULE_11) illegal-address flag set by that reset, cleared by por/ext/wdog
// (RULE_12) watchdog flag set by watchdog reset, cleared by por/ext/illaddr
// (RULE_13) watchdog resets only when build option enables it, no sw disable
// (RULE_14) wait mode keeps watchdog counting; software must wake and service
// (RULE_15) stop mode stops the oscillator, so watchdog stops counting
// (RULE_16) software should service the watchdog just before stop
// (RULE_17) software should write rate bits explicitly, even the default
`ifndef WDRC_REGS_SVH
`define WDRC_REGS_SVH

// register indices, byte address is four times the index
`define WDRC_IDX_SCS        16'h0013
`define WDRC_IDX_SERVICE    16'h1FF0
`define WDRC_IDX_IRQ_STAT   16'h1FF1
`define WDRC_IDX_IRQ_MASK   16'h1FF2
`define WDRC_ADDR_W         16

// system_control_status field positions
`define WDRC_RATE_LO        0
`define WDRC_RATE_HI        1
`define WDRC_ILL_ADDR       2
`define WDRC_WDOG_RST       3
`define WDRC_ILL_STOP       4
`define WDRC_OTHER_LO       5
`define WDRC_OTHER_HI       7

// interrupt status bits
`define WDRC_IRQ_TIMEOUT    0
`define WDRC_IRQ_SERVICE    1
`define WDRC_IRQ_W          2

// reset values
`define WDRC_RATE_RST       2'h0
`define WDRC_OTHER_RST      3'h0

// timing: one second at 32.768 kHz is 2^15 oscillator cycles; tick 2^7
`define WDRC_OSC_HZ         32768
`define WDRC_BASE_TICKS     256
`define WDRC_CNT_W          12

`endif

/* core/wdrc_pkg.sv */
// Purpose: types of the watchdog with reset cause
// Assumes: constants come from wdrc_regs.svh
// Notes:   state is one packed struct
package wdrc_pkg;

  // cause of the reset being reported
  typedef enum logic [2:0] {
    WDRC_CAUSE_NONE  = 3'b000,
    WDRC_CAUSE_POR   = 3'b001,
    WDRC_CAUSE_EXT   = 3'b010,
    WDRC_CAUSE_ILLA  = 3'b011,
    WDRC_CAUSE_ILLS  = 3'b100,
    WDRC_CAUSE_WDOG  = 3'b101
  } wdrc_cause_t;

  // whole module state
  typedef struct packed {
    logic [11:0] count;
    logic [1:0]  rate;
    logic        rate_locked;
    logic        ill_stop;
    logic        ill_addr;
    logic        wdog_rst;
    logic [2:0]  other;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic        system_reset;
    logic        irq;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } wdrc_state_t;

endpackage : wdrc_pkg

/* core/wdrc_top.sv */
// Purpose: watchdog with reset cause flags behind an apb slave
// Assumes: periodic_tick is a one-cycle pulse per periodic interrupt output
// Notes:   cause inputs are one-cycle pulses from the reset controller
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "wdrc_regs.svh"

module wdrc_top
  import wdrc_pkg::*;
#(
  parameter int unsigned BASE_TICKS = `WDRC_BASE_TICKS,
  parameter bit          WDOG_ON    = 1'b1
)(
  input  wire logic        pclk,          // 50 mhz clock
  input  wire logic        presetn,       // async reset, active low
  input  wire logic        psel,          // apb select
  input  wire logic        penable,       // apb access phase
  input  wire logic        pwrite,        // apb direction
  input  wire logic [31:0] paddr,         // apb byte address
  input  wire logic [31:0] pwdata,        // apb write data
  input  wire logic [3:0]  pstrb,         // apb byte strobes
  output logic             pready,        // apb ready
  output logic [31:0]      prdata,        // apb read data
  output logic             pslverr,       // apb error on unmapped
  input  wire logic        periodic_tick, // periodic circuit tick
  input  wire logic        stop_mode,     // cpu in stop mode
  input  wire logic        cpu_in_reset,  // cpu held in reset
  input  wire logic        por_event,     // power-on reset seen
  input  wire logic        ext_event,     // external reset seen
  input  wire logic        ill_addr_event,// illegal address reset seen
  input  wire logic        ill_stop_event,// disabled stop executed
  output logic             system_reset,  // watchdog reset pulse
  output logic             irq            // level interrupt
);

  wdrc_state_t state;
  wdrc_state_t next_state;

  ////////////////////////////////////////////////////////////////////////////
  // decode of a word address to a register index
  function automatic logic hit(input logic [31:0] a,
                               input logic [15:0] idx);
    hit = (a[1:0] == 2'h0) && (a[31:2] == {14'h0, idx});
  endfunction : hit

  // timeout in periodic ticks: base times 1,2,4,8
  function automatic logic [11:0] limit(input logic [1:0] r);
    logic [11:0] base;
    base  = BASE_TICKS[11:0];
    limit = base << r; // RULE_09
  endfunction : limit

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    logic acc;
    logic wr;
    logic m_scs;
    logic m_svc;
    logic m_st;
    logic m_mk;
    logic clr_cnt;
    logic expire;
    logic serviced;
    logic [7:0] scs_rd;
    acc        = psel && penable;
    wr         = acc && pwrite;
    expire     = 1'b0;
    m_scs      = hit(paddr, `WDRC_IDX_SCS);
    m_svc      = hit(paddr, `WDRC_IDX_SERVICE);
    m_st       = hit(paddr, `WDRC_IDX_IRQ_STAT);
    m_mk       = hit(paddr, `WDRC_IDX_IRQ_MASK);
    next_state = state;
    scs_rd     = {state.other, state.ill_stop, state.wdog_rst,
                  state.ill_addr, state.rate};

    // service write: zero in bit 0
    serviced = wr && m_svc && pstrb[0] && !pwdata[0]; // RULE_03
    clr_cnt  = serviced;

    // first control write sets the rate, later ones leave it
    if (wr && m_scs && pstrb[0])
    begin
      next_state.other = pwdata[`WDRC_OTHER_HI:`WDRC_OTHER_LO];
      if (!state.rate_locked)
      begin
        next_state.rate        = pwdata[`WDRC_RATE_HI:`WDRC_RATE_LO]; // RULE_05
        next_state.rate_locked = 1'b1; // RULE_08
        clr_cnt                = 1'b1; // RULE_07
      end
    end

    // counter advances only on periodic ticks, held cleared in stop
    if (cpu_in_reset || stop_mode || clr_cnt)
      next_state.count = 12'h000; // RULE_04 RULE_15
    else if (periodic_tick) // RULE_02 RULE_14
    begin
      if (state.count + 12'h001 >= limit(state.rate))
      begin
        expire           = 1'b1; // RULE_01
        next_state.count = 12'h000;
      end
      else
        next_state.count = state.count + 12'h001;
    end

    // watchdog reset only when the build option allows
    next_state.system_reset = expire && WDOG_ON; // RULE_13

    // reset cause flags
    if (por_event || ext_event || next_state.system_reset)
    begin
      next_state.ill_stop = 1'b0; // RULE_10
      next_state.ill_addr = 1'b0; // RULE_11
    end
    if (por_event || ext_event || ill_addr_event)
      next_state.wdog_rst = 1'b0; // RULE_12
    if (ill_stop_event)
      next_state.ill_stop = 1'b1; // RULE_10
    if (ill_addr_event)
      next_state.ill_addr = 1'b1; // RULE_11
    if (next_state.system_reset)
      next_state.wdog_rst = 1'b1; // RULE_12

    // a reset returns the rate to default and unlocks it
    if (por_event || ext_event || ill_addr_event || next_state.system_reset)
    begin
      next_state.rate        = `WDRC_RATE_RST; // RULE_06
      next_state.rate_locked = 1'b0;
      next_state.other       = `WDRC_OTHER_RST;
    end

    // interrupt status: write one clears, a set wins
    if (wr && m_st && pstrb[0])
      next_state.irq_stat = state.irq_stat & ~pwdata[`WDRC_IRQ_W-1:0];
    if (wr && m_mk && pstrb[0])
      next_state.irq_mask = pwdata[`WDRC_IRQ_W-1:0];
    if (next_state.system_reset)
      next_state.irq_stat[`WDRC_IRQ_TIMEOUT] = 1'b1;
    if (serviced)
      next_state.irq_stat[`WDRC_IRQ_SERVICE] = 1'b1;
    next_state.irq = |(next_state.irq_stat & next_state.irq_mask);

    // apb answer: one wait-free access phase
    next_state.pready  = 1'b0;
    next_state.pslverr = 1'b0;
    next_state.prdata  = 32'h0000_0000;
    // answer launched at the end of setup, so ready, data and error
    // stand exactly in the access cycle and drop together after it
    if (psel && !penable)
    begin
      next_state.pready  = 1'b1;
      next_state.pslverr = !(m_scs || m_svc || m_st || m_mk);
      if (!pwrite && m_scs)
        next_state.prdata = {24'h00_0000, scs_rd};
      else if (!pwrite && m_st)
        next_state.prdata = {30'h0, state.irq_stat};
      else if (!pwrite && m_mk)
        next_state.prdata = {30'h0, state.irq_mask};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= '0;
    else
      state <= next_state;
  end

  // outputs straight from flip-flops
  assign pready       = state.pready;
  assign prdata       = state.prdata;
  assign pslverr      = state.pslverr;
  assign system_reset = state.system_reset;
  assign irq          = state.irq;

endmodule : wdrc_top

/* testbench/wdrc_checker.sv */
// Purpose: port assertions of the watchdog block
// Assumes: zero-wait apb slave
// Notes:   bound to wdrc_top
`timescale 1ns/1ps
module wdrc_checker #(parameter bit WDOG_ON = 1'b1)(
  input wire logic        pclk,          // clock
  input wire logic        presetn,       // reset, low
  input wire logic        psel,          // select
  input wire logic        penable,       // access
  input wire logic [31:0] paddr,         // address
  input wire logic        pready,        // ready
  input wire logic        pslverr,       // error
  input wire logic        periodic_tick, // tick
  input wire logic        stop_mode,     // stop
  input wire logic        cpu_in_reset,  // cpu reset
  input wire logic        system_reset,  // expiry
  input wire logic        irq            // interrupt
);
  logic map_ok;
  // known register addresses
  assign map_ok = paddr inside {32'h4C, 32'h7FC0, 32'h7FC4, 32'h7FC8};
  // one clock domain
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  a_ready_zero_wait: assert property (psel && !penable |=> pready)
    else $error("ready missing after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_unmapped: assert property (psel && !penable && !map_ok |=> pslverr)
    else $error("no error on unmapped address");
  a_ok_mapped: assert property (psel && !penable && map_ok |=> !pslverr)
    else $error("error on mapped address");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_wdog_pulse: assert property (system_reset |=> !system_reset)
    else $error("expiry pulse too long");
  a_wdog_tick: assert property
    (system_reset |-> $past(periodic_tick) || $past(periodic_tick, 2))
    else $error("expiry without tick");
  a_stop_hold: assert property
    (stop_mode [*3] |-> !system_reset)
    else $error("expiry during stop");
  a_cpu_hold: assert property (cpu_in_reset [*3] |-> !system_reset)
    else $error("expiry during cpu reset");
  a_wdog_option: assert property (!WDOG_ON |-> !system_reset)
    else $error("expiry with option off");
  c_expiry: cover property (system_reset);
  c_unmapped: cover property (pslverr);
  c_irq: cover property (irq);
endmodule : wdrc_checker

bind wdrc_top wdrc_checker #(.WDOG_ON(WDOG_ON)) chk_u (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .periodic_tick(periodic_tick),
  .stop_mode(stop_mode), .cpu_in_reset(cpu_in_reset),
  .system_reset(system_reset), .irq(irq));

/* testbench/test_wdrc_top.sv */
// Purpose: self-checking bench of the watchdog block
// Assumes: zero-wait apb slave, four ticks per base period
// Notes:   ticks come by hand, one every two cycles
`timescale 1ns/1ps
module test_wdrc_top;
  localparam int BT = 4;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = 0, pwdata = 0, rd, prdata;
  logic        tick = 0, stop = 0, cpur = 0, err, irq, pready, pslverr;
  logic        sysr, sysr_off;
  logic [3:0]  ev = 0;
  logic [3:0]  evm [4] = '{4'h0, 4'h4, 4'h8, 4'h1};
  logic [7:0]  fexp [4] = '{8'h08, 8'h04, 8'h14, 8'h00};
  int          num_errors = 0, samples_checked = 0, pulses = 0, cyc = 0;
  int          pulses_off = 0;
  int          r, q;
  wdrc_top #(.BASE_TICKS(BT)) dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'hF), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .periodic_tick(tick), .stop_mode(stop),
    .cpu_in_reset(cpur), .por_event(ev[0]), .ext_event(ev[1]),
    .ill_addr_event(ev[2]), .ill_stop_event(ev[3]),
    .system_reset(sysr), .irq(irq));
  // same stimulus into a copy built with the watchdog option off
  wdrc_top #(.BASE_TICKS(BT), .WDOG_ON(1'b0)) dut_off (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .pready(), .prdata(),
    .pslverr(), .periodic_tick(tick), .stop_mode(stop),
    .cpu_in_reset(cpur), .por_event(ev[0]), .ext_event(ev[1]),
    .ill_addr_event(ev[2]), .ill_stop_event(ev[3]),
    .system_reset(sysr_off), .irq());
  // clock
  always #10 pclk = ~pclk;
  // expiry tally and hang guard
  always @(posedge pclk)
  begin
    cyc++;
    if (sysr === 1'b1) pulses++;
    if (sysr_off === 1'b1) pulses_off++;
    if (cyc == 20000)
    begin
      num_errors++;
      print_verdict;
    end
  end
  ////////////////////////////////////////
  task chk(input string n, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task apb(input logic w, input logic [31:0] ad, d);
    psel <= 1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask : apb
  task ticks(input int n);
    repeat (n)
    begin
      tick <= 1;
      @(posedge pclk);
      tick <= 0;
      @(posedge pclk);
    end
    repeat (4) @(posedge pclk);
  endtask : ticks
  task fire(input logic [3:0] m);
    ev <= m;
    @(posedge pclk);
    ev <= 0;
    @(posedge pclk);
  endtask : fire
  task expire(input int n);
    int p;
    p = pulses;
    ticks(n - 1);
    chk("early pulse", p, pulses);
    ticks(1);
    chk("expiry pulse", p + 1, pulses);
  endtask : expire
  task print_verdict;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict
  // main sequence
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, 32'h4C, 0);
    chk("scs reset", 0, rd);
    expire(BT);
    for (r = 0; r < 4; r++)
    begin
      fire(4'h2);
      apb(1, 32'h4C, r);
      apb(1, 32'h4C, r ^ 3);
      expire(BT << r);
    end
    for (r = 0; r < 3; r++)
    begin
      ticks(BT - 1);
      stop <= (r == 0);
      cpur <= (r == 1);
      if (r == 2) apb(1, 32'h4C, 0);
      else ticks(2);
      stop <= 0;
      cpur <= 0;
      expire(BT);
    end
    q = pulses;
    ticks(BT - 1);
    apb(1, 32'h7FC0, 0);
    ticks(BT - 1);
    apb(1, 32'h7FC0, 1);
    chk("service", q, pulses);
    expire(1);
    ticks(BT - 1);
    apb(1, 32'h7FC0, 0);
    stop <= 1;
    ticks(2);
    stop <= 0;
    ticks(BT - 1);
    chk("stop recovery", q + 1, pulses);
    for (r = 0; r < 4; r++)
    begin
      fire(evm[r]);
      apb(0, 32'h4C, 0);
      chk("scs flags", fexp[r], rd);
    end
    apb(1, 32'h4C, 32'h20);
    apb(1, 32'h4C, 32'h03);
    apb(0, 32'h4C, 0);
    chk("scs rmw lock", 0, rd);
    apb(0, 32'h7FC4, 0);
    chk("irq status", 3, rd);
    apb(1, 32'h7FC8, 0);
    repeat (2) @(posedge pclk);
    chk("irq masked", 0, irq);
    apb(1, 32'h7FC8, 3);
    repeat (2) @(posedge pclk);
    chk("irq mask", 1, irq);
    apb(1, 32'h7FC4, 3);
    repeat (2) @(posedge pclk);
    chk("irq clear", 0, irq);
    apb(0, 32'h100, 0);
    chk("unmapped", 1, err);
    chk("option off", 0, pulses_off);
    print_verdict;
  end
endmodule : test_wdrc_top
